// >>> src/cmr_unit.v
/*
 * Control-register move and exception-return unit of the system
 * control coprocessor. Assumes the pipeline issues one op per
 * valid pulse and stalls while standby_o is high.
 */
`timescale 1ns/1ps
`include "cmr_defs.vh"

module cmr_unit #(
    parameter OLD_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Instruction issue
    input  wire        op_valid_i,
    input  wire [2:0]  op_code_i,
    input  wire [4:0]  control_reg_number_i,
    input  wire [4:0]  dest_gpr_i,
    input  wire [63:0] source_gpr_i,
    input  wire        in_delay_slot_i,
    // Exception entry from the pipeline
    input  wire        exc_take_i,
    input  wire [63:0] exc_pc_i,
    input  wire        wake_i,
    // Register file writeback
    output reg         gpr_we_o,
    output reg  [4:0]  gpr_waddr_o,
    output reg  [63:0] gpr_wdata_o,
    // Fetch control
    output reg         redirect_o,
    output reg  [63:0] redirect_pc_o,
    output reg         kill_next_o,
    // Mode and power
    output wire [31:0] processor_mode_flags_o,
    output wire        standby_o,
    output wire        core_clk_en_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [31:0] status_reg;
    reg  [31:0] status_next;
    reg  [63:0] epc_reg;
    reg  [63:0] error_epc_reg;
    reg  [63:0] scratch_reg;
    reg  [63:0] read_value;
    reg         implemented;
    wire        op_live;
    wire        is_mtc;
    wire        is_mfc;
    wire        is_dbl;
    wire        do_eret;
    wire        do_restore;
    wire        do_wait;
    wire        at_error_level;
    wire [5:0]  mode_stack;
    wire [5:0]  stack_pushed;
    wire [5:0]  stack_popped;
    wire [63:0] wval;
    wire [31:0] sr_written;
    wire [63:0] read_word;
    wire [63:0] mfc_value;
    wire [63:0] ret_pc;

    // ------------------------------------------------------------
    // Operation decode
    // ------------------------------------------------------------
    // A trap taken in the same cycle wins over whatever was issued
    assign op_live    = op_valid_i & ~exc_take_i;
    assign is_mtc     = op_valid_i & ((op_code_i == `CMR_OP_MTC) | (op_code_i == `CMR_OP_DMTC));
    assign is_mfc     = op_valid_i & ((op_code_i == `CMR_OP_MFC) | (op_code_i == `CMR_OP_DMFC));
    assign is_dbl     = (op_code_i == `CMR_OP_DMTC) | (op_code_i == `CMR_OP_DMFC);
    assign do_restore = op_valid_i & (op_code_i == `CMR_OP_RESTORE) & OLD_VARIANT;
    assign do_eret    = op_valid_i & (op_code_i == `CMR_OP_ERET) & ~OLD_VARIANT;
    assign do_wait    = op_live & (op_code_i == `CMR_OP_WAIT) & ~OLD_VARIANT;

    // ------------------------------------------------------------
    // Operand shaping
    // ------------------------------------------------------------
    // Word moves sign-extend the low half, as a 32-bit load would
    assign wval       = is_dbl ? source_gpr_i
                      : {{`CMR_WORD_W{source_gpr_i[`CMR_WORD_W-1]}}, source_gpr_i[`CMR_WORD_W-1:0]};
    // Zero-marked status bits can never be set, so they always read zero
    assign sr_written = source_gpr_i[`CMR_WORD_W-1:0] & `CMR_SR_WMASK;
    assign read_word  = {{`CMR_WORD_W{read_value[`CMR_WORD_W-1]}}, read_value[`CMR_WORD_W-1:0]};
    assign mfc_value  = is_dbl ? read_value : read_word;

    // ------------------------------------------------------------
    // Mode stack helpers for the older variant
    // ------------------------------------------------------------
    // Trap entry shifts two bits in; restore shifts them back down and
    // leaves the oldest pair in place, so repeated restores stay sane
    assign mode_stack   = status_reg[`CMR_SR_STACK_HI:`CMR_SR_STACK_LO];
    assign stack_pushed = mode_stack << `CMR_SR_STACK_STEP;
    assign stack_popped = (mode_stack >> `CMR_SR_STACK_STEP) | (mode_stack & `CMR_SR_STACK_TOP);

    // Return target: the error level outranks the exception level
    assign at_error_level = status_reg[`CMR_SR_ERL];
    assign ret_pc         = at_error_level ? error_epc_reg : epc_reg;

    // ------------------------------------------------------------
    // Read mux: the move-from read path; status also drives the mode flags directly
    // ------------------------------------------------------------
    always @* begin
        read_value  = `CMR_ZERO64;
        implemented = 1'b1;
        case (control_reg_number_i)
            `CMR_NUM_STATUS:    read_value = {`CMR_ZERO32, status_reg};
            `CMR_NUM_EPC:       read_value = epc_reg;
            `CMR_NUM_ERROR_EPC: read_value = error_epc_reg;
            `CMR_NUM_SCRATCH:   read_value = scratch_reg;
            default:            implemented = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Status next value; only move-to, trap entry and returns touch it
    // ------------------------------------------------------------
    always @* begin
        status_next = status_reg;
        if (exc_take_i) begin
            // Hardware trap entry raises the level
            if (OLD_VARIANT) begin
                status_next[`CMR_SR_STACK_HI:`CMR_SR_STACK_LO] = stack_pushed;
            end else begin
                status_next[`CMR_SR_EXL] = 1'b1;
            end
        end else if (is_mtc && (control_reg_number_i == `CMR_NUM_STATUS)) begin
            status_next = sr_written;
        end else if (do_restore) begin
            // No jump here: the register jump around it carries the branch
            status_next[`CMR_SR_STACK_HI:`CMR_SR_STACK_LO] = stack_popped;
        end else if (do_eret) begin
            if (at_error_level) begin
                status_next[`CMR_SR_ERL] = 1'b0;
            end else begin
                status_next[`CMR_SR_EXL] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg    <= `CMR_SR_RESET;
            epc_reg       <= `CMR_ZERO64;
            error_epc_reg <= `CMR_ZERO64;
            scratch_reg   <= `CMR_ZERO64;
        end else begin
            status_reg <= status_next;
            if (exc_take_i) begin
                // Trap entry saves the PC of the interrupted instruction
                epc_reg <= exc_pc_i;
            end else if (is_mtc && implemented) begin
                case (control_reg_number_i)
                    `CMR_NUM_EPC:       epc_reg       <= wval;
                    `CMR_NUM_ERROR_EPC: error_epc_reg <= wval;
                    `CMR_NUM_SCRATCH:   scratch_reg   <= wval;
                    default:            scratch_reg   <= scratch_reg;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Writeback and fetch redirect, registered one cycle after issue
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gpr_we_o      <= 1'b0;
            gpr_waddr_o   <= `CMR_GPR_NONE;
            gpr_wdata_o   <= `CMR_ZERO64;
            redirect_o    <= 1'b0;
            redirect_pc_o <= `CMR_ZERO64;
            kill_next_o   <= 1'b0;
        end else begin
            gpr_we_o    <= is_mfc & ~exc_take_i;
            gpr_waddr_o <= dest_gpr_i;
            if (is_mfc) begin
                gpr_wdata_o <= mfc_value;
            end
            redirect_o  <= do_eret & ~exc_take_i;
            // The slot after a return must not run; the pipeline drops it
            kill_next_o <= do_eret & ~exc_take_i;
            if (do_eret) begin
                redirect_pc_o <= ret_pc;
            end
        end
    end

    assign processor_mode_flags_o = status_reg;

    // Standby holds until an interrupt or reset wakes the core
    cmr_standby u_standby (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .enter_i       (do_wait),
        .wake_i        (wake_i),
        .standby_o     (standby_o),
        .core_clk_en_o (core_clk_en_o)
    );
endmodule

// >>> common/cmr_defs.vh
/*
 * Constants for the control-register move and return unit.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CMR_DEFS_VH
`define CMR_DEFS_VH

// ------------------------------------------------------------
// Operation codes from the pipeline
// ------------------------------------------------------------
`define CMR_OP_W            3
`define CMR_OP_NONE         3'h0
`define CMR_OP_MTC          3'h1
`define CMR_OP_MFC          3'h2
`define CMR_OP_DMTC         3'h3
`define CMR_OP_DMFC         3'h4
`define CMR_OP_RESTORE      3'h5
`define CMR_OP_ERET         3'h6
`define CMR_OP_WAIT         3'h7

// ------------------------------------------------------------
// Register numbers
// ------------------------------------------------------------
`define CMR_NUM_W           5
`define CMR_NUM_STATUS      5'h0C
`define CMR_NUM_EPC         5'h0E
`define CMR_NUM_ERROR_EPC   5'h1E
`define CMR_NUM_SCRATCH     5'h16

// ------------------------------------------------------------
// Status register layout
// ------------------------------------------------------------
`define CMR_SR_RESET        32'h0040_0004
`define CMR_SR_WMASK        32'hF27F_FF3F
`define CMR_SR_STACK_LO     0
`define CMR_SR_STACK_HI     5
`define CMR_SR_EXL          1
`define CMR_SR_ERL          2
`define CMR_SR_STACK_STEP   2
`define CMR_SR_STACK_TOP    6'h30
`define CMR_ZERO64          64'h0000_0000_0000_0000
`define CMR_ZERO32          32'h0000_0000
`define CMR_WORD_W          32
`define CMR_GPR_NONE        5'h00

`endif

// >>> src/cmr_standby.v
/*
 * Standby control: holds the core clock-gate request low while idle.
 * Assumes wake_i is already synchronous to clk_i.
 */
`timescale 1ns/1ps
module cmr_standby (
    // Clock and reset
    input  wire clk_i,
    input  wire rst_i,
    // Control
    input  wire enter_i,
    input  wire wake_i,
    // Status
    output reg  standby_o,
    output wire core_clk_en_o
);
    // ------------------------------------------------------------
    // Standby flag; a fresh entry wins over a wake in the same cycle
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            standby_o <= 1'b0;
        end else if (enter_i) begin
            standby_o <= 1'b1;
        end else if (wake_i) begin
            standby_o <= 1'b0;
        end
    end

    // Gating the core clock is what cuts power in standby
    assign core_clk_en_o = ~standby_o;
endmodule

// >>> dv/cmr_unit_asserts.sv
/* Checker for the move and return unit.
   Assumes it is bound into cmr_unit and sees only its ports. */
`timescale 1ns/1ps
module cmr_unit_asserts #(parameter OLD_VARIANT = 1'b0) (
    input wire        clk_i, rst_i, op_valid_i, exc_take_i,
    input wire [2:0]  op_code_i,
    input wire [4:0]  control_reg_number_i, dest_gpr_i, gpr_waddr_o,
    input wire        gpr_we_o, redirect_o, kill_next_o, standby_o, core_clk_en_o,
    input wire [63:0] gpr_wdata_o,
    input wire [31:0] processor_mode_flags_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A trap beats any op in the same cycle
    wire go = op_valid_i && !exc_take_i;
    wire rd = go && (op_code_i == 3'h2 || op_code_i == 3'h4);
    wire n_impl = control_reg_number_i == 5'h0C || control_reg_number_i == 5'h0E ||
                  control_reg_number_i == 5'h1E || control_reg_number_i == 5'h16;
    read_wb_a: assert property (rd |=> gpr_we_o && gpr_waddr_o == $past(dest_gpr_i))
        else $error("read writeback missing");
    we_cause_a: assert property (gpr_we_o |-> $past(rd))
        else $error("writeback without read");
    dbl_status_a: assert property (go && op_code_i == 3'h4 && control_reg_number_i == 5'h0C
        |=> gpr_wdata_o[63:32] == 32'h0) else $error("status upper half not zero");
    unimpl_zero_a: assert property (rd && !n_impl |=> gpr_wdata_o == 64'h0)
        else $error("unimplemented number read nonzero");
    flags_hold_a: assert property (!$past(op_valid_i) && !$past(exc_take_i)
        |-> $stable(processor_mode_flags_o)) else $error("flags changed with no op");
    zero_bits_a: assert property ((processor_mode_flags_o & 32'h0D8000C0) == 32'h0)
        else $error("zero field set in flags");
    eret_go_a: assert property (go && op_code_i == 3'h6 && !OLD_VARIANT
        |=> redirect_o && kill_next_o) else $error("return did not redirect");
    kill_pair_a: assert property (redirect_o |-> kill_next_o ##1 !redirect_o)
        else $error("redirect without kill");
    wait_a: assert property (go && op_code_i == 3'h7 && !OLD_VARIANT
        |=> standby_o && !core_clk_en_o) else $error("wait did not enter standby");
    restore_pop_a: assert property (go && op_code_i == 3'h5 && OLD_VARIANT
        |=> processor_mode_flags_o[3:0] == $past(processor_mode_flags_o[5:2]))
        else $error("restore did not pop mode stack");
    restore_nojump_a: assert property (go && op_code_i == 3'h5 |=> !redirect_o)
        else $error("restore redirected fetch");
endmodule
bind cmr_unit cmr_unit_asserts #(.OLD_VARIANT(OLD_VARIANT)) cmr_unit_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .exc_take_i(exc_take_i),
    .op_code_i(op_code_i), .control_reg_number_i(control_reg_number_i), .dest_gpr_i(dest_gpr_i),
    .gpr_waddr_o(gpr_waddr_o), .gpr_we_o(gpr_we_o), .redirect_o(redirect_o), .kill_next_o(kill_next_o),
    .standby_o(standby_o), .core_clk_en_o(core_clk_en_o), .gpr_wdata_o(gpr_wdata_o),
    .processor_mode_flags_o(processor_mode_flags_o));

// >>> dv/cmr_pipe_model.sv
/* Pipeline model: issues privileged ops and captures writeback and redirects.
   Assumes the unit's outputs are registered on clk_i. */
`timescale 1ns/1ps
module cmr_pipe_model (
    input  wire        clk_i,
    input  wire        gpr_we_i,
    input  wire [63:0] gpr_wdata_i,
    input  wire        redirect_i,
    input  wire [63:0] redirect_pc_i,
    output reg         op_valid_o,
    output reg  [2:0]  op_code_o,
    output reg  [4:0]  num_o,
    output reg  [63:0] src_o,
    output reg         exc_take_o
);
    reg [63:0] wb_data;
    reg [63:0] jump_pc;
    initial {op_valid_o, op_code_o, num_o, src_o, exc_take_o} = 0;
    // Capture what the unit hands back; the bench judges it later
    always @(posedge clk_i) begin
        if (gpr_we_i) wb_data <= gpr_wdata_i;
        if (redirect_i) jump_pc <= redirect_pc_i;
    end
    // One op or trap per call, held up to the taking edge
    task issue(input [2:0] op, input [4:0] num, input [63:0] src, input trap);
        begin
            @(posedge clk_i);
            #1 {op_valid_o, op_code_o, num_o, src_o, exc_take_o} = {~trap, op, num, src, trap};
            @(posedge clk_i);
            #1 {op_valid_o, exc_take_o} = 2'h0;
            src_o = ~src; // Released bus must not keep the last value
        end
    endtask
endmodule

// >>> dv/testbench.sv
/* Bench for the move and return unit, new and older variants.
   Assumes the pipeline model drives every issue input except in_delay_slot_i, which the bench ties to a constant. */
`timescale 1ns/1ps
module testbench;
    reg clk_i = 0, rst_i = 1, wake_i = 0;
    integer fails = 0, compares = 0;
    wire gpr_we, redirect, standby, clk_en, valid, trap;
    wire [63:0] wdata, rpc, src;
    wire [31:0] flags, old_flags;
    wire old_redirect, old_standby;
    wire [4:0] num;
    wire [2:0] code;
    cmr_pipe_model cmr_pipe_model_inst (.clk_i(clk_i), .gpr_we_i(gpr_we), .gpr_wdata_i(wdata),
        .redirect_i(redirect), .redirect_pc_i(rpc), .op_valid_o(valid), .op_code_o(code),
        .num_o(num), .src_o(src), .exc_take_o(trap));
    cmr_unit cmr_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(valid), .op_code_i(code),
        .control_reg_number_i(num), .dest_gpr_i(num), .source_gpr_i(src), .in_delay_slot_i(1'b0),
        .exc_take_i(trap), .exc_pc_i(src), .wake_i(wake_i), .gpr_we_o(gpr_we), .gpr_waddr_o(),
        .gpr_wdata_o(wdata), .redirect_o(redirect), .redirect_pc_o(rpc), .kill_next_o(),
        .processor_mode_flags_o(flags), .standby_o(standby), .core_clk_en_o(clk_en));
    // Older core on the same issue stream, for the mode stack and restore
    if (1) begin : old_core
        cmr_unit #(.OLD_VARIANT(1'b1)) cmr_unit_inst (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(valid),
            .op_code_i(code), .control_reg_number_i(num), .dest_gpr_i(num), .source_gpr_i(src),
            .in_delay_slot_i(1'b1), .exc_take_i(trap), .exc_pc_i(src), .wake_i(wake_i), .gpr_we_o(),
            .gpr_waddr_o(), .gpr_wdata_o(), .redirect_o(old_redirect), .redirect_pc_o(), .kill_next_o(),
            .processor_mode_flags_o(old_flags), .standby_o(old_standby), .core_clk_en_o());
    end
    initial forever #12.5 clk_i = ~clk_i;
    task check(input string what, input [63:0] exp, input [63:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task go(input [2:0] o, input [4:0] n, input [63:0] v, input t);
        cmr_pipe_model_inst.issue(o, n, v, t);
    endtask
    // Stale capture is cleared so a missing writeback shows
    task rd(input [2:0] o, input [4:0] n, input [63:0] exp);
        begin
            cmr_pipe_model_inst.wb_data = 64'hX;
            go(o, n, 64'h0, 1'b0);
            @(posedge clk_i) #1 check("read data", exp, cmr_pipe_model_inst.wb_data);
        end
    endtask
    task t_status;
        begin
            go(3'h1, 5'h0C, 64'h0000_0000_FFFF_FFFF, 1'b0);
            rd(3'h2, 5'h0C, 64'hFFFF_FFFF_F27F_FF3F);
            rd(3'h4, 5'h0C, 64'h0000_0000_F27F_FF3F);
            check("flags", 64'hF27F_FF3F, {32'h0, flags});
            $display("status test done");
        end
    endtask
    task t_double;
        begin
            go(3'h3, 5'h16, 64'h1234_5678_9ABC_DEF0, 1'b0);
            rd(3'h4, 5'h16, 64'h1234_5678_9ABC_DEF0);
            rd(3'h2, 5'h16, 64'hFFFF_FFFF_9ABC_DEF0);
            go(3'h1, 5'h05, 64'h1234, 1'b0);
            rd(3'h2, 5'h05, 64'h0);
            $display("double test done");
        end
    endtask
    task t_eret;
        begin
            go(3'h1, 5'h0C, 64'h0, 1'b0);
            go(3'h0, 5'h00, 64'h8000_0180, 1'b1);
            @(posedge clk_i) #1 check("trap flags", 64'h2, {32'h0, flags});
            go(3'h6, 5'h00, 64'h0, 1'b0);
            @(posedge clk_i) #1 check("return pc", 64'h8000_0180, cmr_pipe_model_inst.jump_pc);
            check("flags after return", 64'h0, {32'h0, flags});
            go(3'h1, 5'h1E, 64'h9FC0_0400, 1'b0);
            go(3'h1, 5'h0C, 64'h4, 1'b0);
            go(3'h6, 5'h00, 64'h0, 1'b0);
            // The word move sign-extends bit 31 into the saved error PC
            @(posedge clk_i) #1 check("error return pc", 64'hFFFF_FFFF_9FC0_0400, cmr_pipe_model_inst.jump_pc);
            check("flags after error return", 64'h0, {32'h0, flags});
            $display("return test done");
        end
    endtask
    task t_wait;
        begin
            go(3'h7, 5'h00, 64'h0, 1'b0);
            @(posedge clk_i) #1 check("standby", 64'h2, {62'h0, standby, clk_en});
            wake_i = 1;
            @(posedge clk_i) #1 wake_i = 0;
            @(posedge clk_i) #1 check("awake", 64'h1, {62'h0, standby, clk_en});
            $display("wait test done");
        end
    endtask
    // Older core: trap pushes the mode stack, restore pops it with no jump
    task t_restore;
        begin
            go(3'h1, 5'h0C, 64'h3, 1'b0);
            go(3'h0, 5'h00, 64'h0, 1'b1);
            @(posedge clk_i) #1 check("pushed stack", 64'hC, {32'h0, old_flags});
            go(3'h5, 5'h00, 64'h0, 1'b0);
            check("restore jump", 64'h0, {63'h0, old_redirect});
            check("popped stack", 64'h3, {32'h0, old_flags});
            check("restore ignored", 64'h3, {32'h0, flags});
            check("old standby", 64'h0, {63'h0, old_standby});
            $display("restore test done");
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Whole sequence is well under a thousand cycles
    initial begin
        #25000;
        fails = fails + 1;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        #1 rst_i = 0;
        t_status;
        t_double;
        t_eret;
        t_wait;
        t_restore;
        final_report;
    end
endmodule
